// >>> src/event_counting_timer.sv
// event counting 16-bit timer core
//
// What this block does
// - in counter mode an enabled timer output toggles on every reload
// - the edge select also sets the timer output's starting level
// - written start count applies only to first pass, later passes start at 0001H
// - counter mode adds one per selected timer input transition
// - comparator counter mode counts comparator output edges instead
// - polarity bit picks rising or falling comparator edges
// - comparator counter mode bypasses the prescaler
// - capture interrupts default to both events, config can restrict to one
// - reaching the reload value reloads the count to 0001H
// - count is a 16-bit value in writable high and low bytes
`timescale 1ns/1ps
module event_counting_timer
  import event_counting_timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire event_counting_timer_pkg::timer_control_one_s timer_control_one,
  input wire logic output_alt_enable,
  // count and reload byte writes
  input wire event_counting_timer_pkg::byte_write_s count_write,
  input wire event_counting_timer_pkg::byte_write_s reload_write,
  // events
  input wire logic timer_input,
  input wire logic comparator_output,
  // status
  output logic [15:0] count,
  output logic [15:0] reload_value,
  output logic timer_output,
  output logic timer_irq,
  output logic capture_flag,
  output logic [15:0] capture_value
);
  import event_counting_timer_pkg::*;
  `include "event_counting_timer_defines.svh"

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // polarity high picks the rising edge, low the falling one
  function automatic logic pick_edge(input logic pol, input logic r, input logic f);
    pick_edge = pol ? r : f;
  endfunction

  // wrap to the restart value, never to zero, so later passes are reload events long
  function automatic logic [15:0] step_count(input logic [15:0] cur, input logic wrap);
    if (wrap) begin
      step_count = `ECT_COUNT_RESTART;
    end else begin
      step_count = cur + 16'h0001;
    end
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // three cycles from pin to count; a pin level held for less than one cycle can be missed
  logic tin_rise;
  logic tin_fall;
  logic cmp_rise;
  logic cmp_fall;
  edge_sync u_tin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(timer_input),
    .level(),
    .rise(tin_rise),
    .fall(tin_fall)
  );
  edge_sync u_cmp_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(comparator_output),
    .level(),
    .rise(cmp_rise),
    .fall(cmp_fall)
  );

  // ---------------------------------------------------------------
  // mode decode and edge selection
  // ---------------------------------------------------------------
  wire logic is_counter = timer_control_one.mode == mode_counter;
  wire logic is_cmp = timer_control_one.mode == mode_comparator_counter;
  wire logic is_capture = timer_control_one.mode == mode_capture;
  wire logic tin_edge = pick_edge(timer_control_one.input_polarity_select, tin_rise, tin_fall);
  wire logic cmp_edge = pick_edge(timer_control_one.input_polarity_select, cmp_rise, cmp_fall);

  // ---------------------------------------------------------------
  // prescaler, used by the capture mode only
  // ---------------------------------------------------------------
  logic [7:0] prescale_cnt;
  wire logic [7:0] prescale_top = 8'(({1'b0, 8'h01} << timer_control_one.prescale) - 9'h001);
  wire logic prescale_tick = prescale_cnt >= prescale_top;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_cnt <= 8'h00;
    end else if (!timer_control_one.enable || prescale_tick) begin
      prescale_cnt <= 8'h00;
    end else begin
      prescale_cnt <= prescale_cnt + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // count events
  // ---------------------------------------------------------------
  // counter mode counts input edges directly; comparator mode skips prescaler
  wire logic counter_event = is_counter && tin_edge;
  wire logic comparator_event = is_cmp && cmp_edge;
  wire logic capture_tick = is_capture && prescale_tick;
  wire logic count_event = timer_control_one.enable &&
    (counter_event || comparator_event || capture_tick);
  wire logic capture_event = timer_control_one.enable && is_capture && tin_edge;
  wire logic at_reload = count == reload_value;
  wire logic reload_event = count_event && at_reload;

  // ---------------------------------------------------------------
  // count register
  // ---------------------------------------------------------------
  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (count_event) begin
      next_count = step_count(count, at_reload);
    end
    // byte writes land at the next edge, counting goes on from there
    if (count_write.write_high) begin
      next_count[15:8] = count_write.data;
    end
    if (count_write.write_low) begin
      next_count[7:0] = count_write.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `ECT_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ---------------------------------------------------------------
  // reload register
  // ---------------------------------------------------------------
  // reload high byte waits in a holding register for the low byte write,
  // so the compare never sees a half-updated value
  logic [7:0] reload_hold;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_hold <= 8'hff;
    end else if (reload_write.write_high) begin
      reload_hold <= reload_write.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_value <= `ECT_RELOAD_RESET;
    end else if (reload_write.write_low) begin
      reload_value <= {reload_hold, reload_write.data};
    end
  end

  // ---------------------------------------------------------------
  // timer output
  // ---------------------------------------------------------------
  // while disabled the level follows the edge choice, so it starts right
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output <= 1'b0;
    end else if (!timer_control_one.enable) begin
      timer_output <= timer_control_one.input_polarity_select;
    end else if (reload_event && output_alt_enable && is_counter) begin
      timer_output <= ~timer_output;
    end
  end

  // ---------------------------------------------------------------
  // capture and interrupt
  // ---------------------------------------------------------------
  wire logic allow_capture_irq = timer_control_one.interrupt_source_config != `ECT_ISRC_RELOAD;
  wire logic allow_reload_irq = !is_capture ||
    (timer_control_one.interrupt_source_config != `ECT_ISRC_CAPTURE);
  wire logic flag_set = capture_event && allow_capture_irq;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= flag_set || (reload_event && allow_reload_irq);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value <= 16'h0000;
    end else if (capture_event) begin
      capture_value <= count;
    end
  end

  // flag names the interrupt's cause: a capture that may not interrupt leaves it,
  // a capture that may wins over a reload in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_flag <= 1'b0;
    end else if (flag_set) begin
      capture_flag <= 1'b1;
    end else if (reload_event) begin
      capture_flag <= 1'b0;
    end
  end
endmodule

// >>> inc/event_counting_timer_defines.svh
// constants for the event counting timer
`ifndef EVENT_COUNTING_TIMER_DEFINES_SVH
`define EVENT_COUNTING_TIMER_DEFINES_SVH
`define ECT_COUNT_RESTART 16'h0001
`define ECT_COUNT_RESET 16'h0001
`define ECT_RELOAD_RESET 16'hffff
`define ECT_PRESCALE_RESET 3'h0
`define ECT_ISRC_BOTH 2'h0
`define ECT_ISRC_CAPTURE 2'h2
`define ECT_ISRC_RELOAD 2'h3
`endif

// >>> inc/event_counting_timer_pkg.sv
// types for the event counting timer
package event_counting_timer_pkg;
  typedef enum logic [1:0] {
    mode_counter = 2'b00,
    mode_comparator_counter = 2'b01,
    mode_capture = 2'b10,
    mode_other = 2'b11
  } timer_mode_e;
  typedef struct packed {
    logic enable;
    timer_mode_e mode;
    logic input_polarity_select;
    logic [2:0] prescale;
    logic [1:0] interrupt_source_config;
  } timer_control_one_s;
  typedef struct packed {
    logic write_high;
    logic write_low;
    logic [7:0] data;
  } byte_write_s;
endpackage

// >>> src/edge_sync.sv
// two-stage synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // signal
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stage;
  logic last;
  // meta feeds only stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stage <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= din;
      stage <= meta;
      last <= stage;
    end
  end
  assign level = stage;
  assign rise = stage & ~last;
  assign fall = ~stage & last;
endmodule

// >>> tb/event_source.sv
// pin model driving timer input or comparator output edges
`timescale 1ns/1ps
module event_source (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] hold,
  output logic pin
);
  logic [1:0] n = 2'h0;
  // ----
  // each level stands hold+1 cycles, never under one
  // ----
  initial pin = 1'b0;
  always @(posedge clk) begin
    n <= (go && n != hold) ? n + 2'h1 : 2'h0;
    if (go && n == hold)
      pin <= ~pin;
  end
endmodule

// >>> tb/event_counting_timer_props.sv
// assertion checker for the event counting timer
`timescale 1ns/1ps
module event_counting_timer_props
  import event_counting_timer_pkg::*;
(
  // levels
  input wire logic clk, rst_n, output_alt_enable, timer_input, comparator_output,
  input wire logic timer_output, timer_irq, capture_flag,
  // configuration and status
  input wire event_counting_timer_pkg::timer_control_one_s timer_control_one,
  input wire event_counting_timer_pkg::byte_write_s count_write,
  input wire logic [15:0] count, reload_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire timer_control_one_s t = timer_control_one;
  wire quiet = t.enable && !count_write.write_high && !count_write.write_low;
  // ----
  // events land three edges after the pin edge
  // ----
  sequence pin_up;
    quiet && t.mode == mode_counter && t.input_polarity_select && $rose(timer_input);
  endsequence
  sequence cmp_edge;
    quiet && t.mode == mode_comparator_counter &&
      (t.input_polarity_select ? $rose(comparator_output) : $fell(comparator_output));
  endsequence
  // an earlier edge may still land at the trigger edge, so compare against two back
  chk_count_step: assert property (pin_up |-> ##3
    ($past(count, 2) == reload_value || count == $past(count, 2) + 16'h0001))
    else $error("count step missed");
  chk_reload_wrap: assert property (pin_up |-> ##3
    ($past(count, 2) != reload_value || count == 16'h0001))
    else $error("reload wrap missed");
  chk_cmp_step: assert property (cmp_edge |-> ##3
    ($past(count, 2) == reload_value || count == $past(count, 2) + 16'h0001))
    else $error("comparator step missed");
  chk_output_toggle: assert property (timer_irq && quiet && t.mode == mode_counter && output_alt_enable |-> timer_output != $past(timer_output))
    else $error("output did not toggle");
  chk_idle_level: assert property (!t.enable [*2] |-> timer_output == $past(t.input_polarity_select))
    else $error("idle output level wrong");
  chk_irq_source: assert property (timer_irq && t.mode == mode_capture && t.interrupt_source_config[1] |-> capture_flag == !t.interrupt_source_config[0])
    else $error("irq from masked source");
  chk_low_byte: assert property (count_write.write_low && !count_write.write_high && !t.enable |=> count[7:0] == $past(count_write.data))
    else $error("low byte write lost");
  chk_high_byte: assert property (count_write.write_high && !count_write.write_low && !t.enable |=> count[15:8] == $past(count_write.data))
    else $error("high byte write lost");
endmodule
bind event_counting_timer event_counting_timer_props chk_u (.clk, .rst_n, .output_alt_enable, .timer_input,
  .comparator_output, .timer_output, .timer_irq, .capture_flag, .timer_control_one, .count_write, .count, .reload_value);

// >>> tb/event_counting_timer_tb.sv
// self-checking bench for the event counting timer
`timescale 1ns/1ps
module event_counting_timer_tb;
  import event_counting_timer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic alt = 1'b0;
  logic go = 1'b0;
  logic clr = 1'b1;
  logic [1:0] hold = 2'h0;
  timer_control_one_s tc = '0;
  byte_write_s cw = '0;
  byte_write_s rw = '0;
  logic tin, cmp, tout, irq, cflag;
  logic [15:0] cnt, rld, cap, n_ev = 16'h0;
  int err_total = 0, n_compared = 0, cyc = 0, nc = 0, nr = 0;
  wire ln = (tc.mode == mode_counter) ? tin : cmp;
  event_source src_t (.clk, .go, .hold, .pin(tin));
  event_source src_c (.clk, .go, .hold(~hold), .pin(cmp));
  event_counting_timer dut_u (.clk, .rst_n, .timer_control_one(tc), .output_alt_enable(alt), .count_write(cw),
    .reload_write(rw), .timer_input(tin), .comparator_output(cmp), .count(cnt), .reload_value(rld),
    .timer_output(tout), .timer_irq(irq), .capture_flag(cflag), .capture_value(cap));
  initial forever #2.5 clk = ~clk;
  // ----
  // monitors, checks and stimulus
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_ev <= clr ? 16'h0 : n_ev + 16'(tc.input_polarity_select ? $rose(ln) : $fell(ln));
    nc <= clr ? 0 : nc + int'(irq && cflag);
    nr <= clr ? 0 : nr + int'(irq && !cflag);
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bytes land one edge after their strobe
  task automatic wr16(input logic rel, input logic [15:0] v);
    for (int h = 1; h >= 0; h--) begin
      @(posedge clk);
      if (rel) rw <= '{h[0], !h[0], h[0] ? v[15:8] : v[7:0]};
      else cw <= '{h[0], !h[0], h[0] ? v[15:8] : v[7:0]};
      @(posedge clk);
      rw <= '0;
      cw <= '0;
    end
  endtask
  function automatic logic [16:0] model(input logic [15:0] s, input logic [15:0] r, input logic [15:0] n);
    logic p = 1'b0;
    repeat (n) begin
      p ^= (s == r);
      s = (s == r) ? 16'h0001 : s + 16'h0001;
    end
    return {p, s};
  endfunction
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic run(input logic [15:0] s, input logic [15:0] r, input int k);
    wr16(1'b0, s);
    wr16(1'b1, r);
    tick(3);
    chk({15'h0, tout}, {15'h0, tc.input_polarity_select});
    chk(rld, r);
    tc.enable <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    go <= 1'b1;
    tick(k);
    go <= 1'b0;
    tick(60);
  endtask
  initial begin
    logic [15:0] s, r;
    logic [16:0] e;
    void'($urandom(39));
    tick(5);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = 16'h0003 + 16'($urandom_range(12));
      s = (i < 2) ? 16'h0001 : 16'h0001 + 16'($urandom_range(r - 1));
      @(posedge clk);
      tc <= '{1'b0, timer_mode_e'({1'b0, i[1]}), i[0], 3'($urandom), 2'h0};
      alt <= 1'($urandom);
      hold <= 2'($urandom);
      run(s, r, 40 + $urandom_range(60));
      e = model(s, r, n_ev);
      chk(cnt, e[15:0]);
      if (alt && !i[1]) chk({15'h0, tout}, {15'h0, i[0] ^ e[16]});
      tc.enable <= 1'b0;
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      tc <= '{1'b0, mode_capture, 1'b1, 3'h0, (k == 0) ? 2'h0 : 2'(k + 1)};
      run(16'h0001, 16'h0010, 40);
      chk({15'h0, cap >= 16'h0001 && cap <= 16'h0010}, 16'h0001);
      chk({15'h0, nc > 0}, {15'h0, k != 2});
      chk({15'h0, nr > 0}, {15'h0, k != 1});
      tc.enable <= 1'b0;
    end
    close_out();
  end
endmodule
